// [verilog/cpu_instruction_decode.sv]
// Instruction decoder and cycle sequencer for the 8-bit core.
// Words, addresses and datapath status arrive from logic on core_clk; no input is synchronised.

`timescale 1ns/100ps

module cpu_instruction_decode (
  input  wire logic                           core_clk,
  input  wire logic                           nrst,
  input  wire logic [decode_pkg::IW-1:0]      instr_word,
  input  wire logic                           instr_valid,
  input  wire logic [decode_pkg::PCW-1:0]     instr_addr,
  input  wire logic [7:0]                     acc_value,
  input  wire logic [decode_pkg::PAGE_W-1:0]  program_page_latch,
  input  wire logic                           indirect_pointer0_msb,
  input  wire logic                           indirect_pointer1_msb,
  input  wire logic                           cond_true,
  output logic [1:0]                          phase,
  output logic                                cycle_start,
  output logic                                word_taken,
  output decode_pkg::op_t                     op,
  output logic                                nop_cycle,
  output logic                                extra_cycle,
  output logic [decode_pkg::FILE_W-1:0]       file_addr,
  output logic                                dest_to_file,
  output logic [decode_pkg::BIT_W-1:0]        bit_num,
  output logic [decode_pkg::LIT_W-1:0]        literal8,
  output logic [decode_pkg::PAGE_W-1:0]       page_literal,
  output logic [decode_pkg::BANK_W-1:0]       bank_literal,
  output logic                                ptr_sel,
  output logic [decode_pkg::OFS_W-1:0]        ptr_offset,
  output logic [decode_pkg::MODE_W-1:0]       pointer_step_mode,
  output logic [decode_pkg::PCW-1:0]          jump_target,
  output logic                                file_read,
  output logic                                file_write,
  output logic                                acc_write,
  output logic                                upd_c,
  output logic                                upd_dc,
  output logic                                upd_z,
  output logic                                upd_to_pd,
  output logic                                indirect_prog_access
);

  phase_if ph ();

  cycle_phase_div u_div (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ph       (ph.src)
  );

  assign phase = ph.count;

  // ----------------------------------------------------------------
  // Decode of the word on offer
  // ----------------------------------------------------------------
  logic [decode_pkg::IW-1:0]  w;
  decode_pkg::op_t            next_op;
  logic                       next_file_op;
  logic                       next_always_wr;
  logic                       next_acc_only;
  logic                       next_pc_change;
  logic                       next_skip_op;
  logic                       next_ptr_op;
  logic                       next_c;
  logic                       next_dc;
  logic                       next_z;
  logic                       next_ptr_sel;
  logic                       next_extra;
  logic [decode_pkg::PCW-1:0] next_target;
  logic [decode_pkg::PCW-1:0] pc_plus1;

  assign w        = instr_valid ? instr_word : decode_pkg::NOP_WORD; // RL1
  assign pc_plus1 = instr_addr + decode_pkg::PCW'(1);

  always_comb begin
    next_op        = decode_pkg::OP_NOP; // RL25
    next_file_op   = 1'b0;
    next_always_wr = 1'b0;
    next_acc_only  = 1'b0;
    next_pc_change = 1'b0;
    next_skip_op   = 1'b0;
    next_ptr_op    = 1'b0;
    casez (w)
      // Byte file operations
      14'b00_0111_????????: next_op = decode_pkg::OP_ADDWF;
      14'b11_1101_????????: next_op = decode_pkg::OP_ADD_WITH_CARRY_OP; // RL17
      14'b00_0101_????????: next_op = decode_pkg::OP_ANDWF;
      14'b11_0111_????????: next_op = decode_pkg::OP_ASR; // RL17
      14'b11_0101_????????: next_op = decode_pkg::OP_LSL; // RL17
      14'b11_0110_????????: next_op = decode_pkg::OP_LSR; // RL17
      14'b00_0001_1???????: next_op = decode_pkg::OP_CLRF;
      14'b00_0001_0000_00??: next_op = decode_pkg::OP_CLRW;
      14'b00_1001_????????: next_op = decode_pkg::OP_COMF;
      14'b00_0011_????????: next_op = decode_pkg::OP_DECF;
      14'b00_1010_????????: next_op = decode_pkg::OP_INCF;
      14'b00_0100_????????: next_op = decode_pkg::OP_IORWF;
      14'b00_1000_????????: next_op = decode_pkg::OP_MOVF;
      14'b00_0000_1???????: next_op = decode_pkg::OP_MOVWF;
      14'b00_1101_????????: next_op = decode_pkg::OP_RLF;
      14'b00_1100_????????: next_op = decode_pkg::OP_RRF;
      14'b00_0010_????????: next_op = decode_pkg::OP_SUBWF;
      14'b11_1011_????????: next_op = decode_pkg::OP_SUBTRACT_WITH_BORROW_OP; // RL17
      14'b00_1110_????????: next_op = decode_pkg::OP_SWAPF;
      14'b00_0110_????????: next_op = decode_pkg::OP_XORWF;
      14'b00_1011_????????: next_op = decode_pkg::OP_DECSZ; // RL18
      14'b00_1111_????????: next_op = decode_pkg::OP_INCSZ; // RL18
      // Bit file operations
      14'b01_00??_????????: next_op = decode_pkg::OP_BCF;
      14'b01_01??_????????: next_op = decode_pkg::OP_BSF;
      14'b01_10??_????????: next_op = decode_pkg::OP_BTSC; // RL18
      14'b01_11??_????????: next_op = decode_pkg::OP_BTSS; // RL18
      // Literal operations
      14'b11_1110_????????: next_op = decode_pkg::OP_ADD_LITERAL_OP; // RL19
      14'b11_1001_????????: next_op = decode_pkg::OP_ANDLW; // RL19
      14'b11_1000_????????: next_op = decode_pkg::OP_IORLW; // RL19
      14'b00_0000_001?????: next_op = decode_pkg::OP_BANKLD;
      14'b11_0001_1???????: next_op = decode_pkg::OP_PAGELD;
      14'b11_0000_????????: next_op = decode_pkg::OP_MOVLW; // RL19
      14'b11_1100_????????: next_op = decode_pkg::OP_LITERAL_MINUS_ACC_OP; // RL19
      14'b11_1010_????????: next_op = decode_pkg::OP_XORLW; // RL19
      // Control operations
      14'b11_001?_????????: next_op = decode_pkg::OP_RELBR;
      14'b00_0000_0000_1011: next_op = decode_pkg::OP_ACCBR; // RL20
      14'b10_0???_????????: next_op = decode_pkg::OP_CALL;
      14'b00_0000_0000_1010: next_op = decode_pkg::OP_ACCCALL; // RL20
      14'b10_1???_????????: next_op = decode_pkg::OP_JUMP;
      14'b00_0000_0000_1001: next_op = decode_pkg::OP_IRET; // RL20
      14'b11_0100_????????: next_op = decode_pkg::OP_RETLIT;
      14'b00_0000_0000_1000: next_op = decode_pkg::OP_RET; // RL20
      // Inherent operations
      14'b00_0000_0110_0100: next_op = decode_pkg::OP_WDTCLR; // RL21
      14'b00_0000_0110_0010: next_op = decode_pkg::OP_OPTLD;
      14'b00_0000_0000_0001: next_op = decode_pkg::OP_SWRESET; // RL21
      14'b00_0000_0110_0011: next_op = decode_pkg::OP_STANDBY; // RL21
      14'b00_0000_0110_01??: next_op = decode_pkg::OP_TRISLD;
      // Pointer operations
      14'b11_0001_0???????: next_op = decode_pkg::OP_PTRADD;
      14'b00_0000_0001_0???: next_op = decode_pkg::OP_ILOAD; // RL16
      14'b11_1111_0???????: next_op = decode_pkg::OP_ILOADK;
      14'b00_0000_0001_1???: next_op = decode_pkg::OP_ISTORE; // RL16
      14'b11_1111_1???????: next_op = decode_pkg::OP_ISTOREK;
      default:              next_op = decode_pkg::OP_NOP; // RL25
    endcase

    // Instruction classes
    case (next_op)
      decode_pkg::OP_ADDWF, decode_pkg::OP_ADD_WITH_CARRY_OP, decode_pkg::OP_ANDWF, decode_pkg::OP_ASR,
      decode_pkg::OP_LSL, decode_pkg::OP_LSR, decode_pkg::OP_COMF, decode_pkg::OP_DECF,
      decode_pkg::OP_INCF, decode_pkg::OP_IORWF, decode_pkg::OP_MOVF, decode_pkg::OP_RLF,
      decode_pkg::OP_RRF, decode_pkg::OP_SUBWF, decode_pkg::OP_SUBTRACT_WITH_BORROW_OP, decode_pkg::OP_SWAPF,
      decode_pkg::OP_XORWF: next_file_op = 1'b1; // RL7
      decode_pkg::OP_DECSZ, decode_pkg::OP_INCSZ, decode_pkg::OP_BTSC, decode_pkg::OP_BTSS: begin
        next_file_op = 1'b1;
        next_skip_op = 1'b1; // RL4
      end
      decode_pkg::OP_CLRF, decode_pkg::OP_MOVWF, decode_pkg::OP_BCF, decode_pkg::OP_BSF: begin
        next_file_op   = 1'b1; // RL7
        next_always_wr = 1'b1;
      end
      decode_pkg::OP_CLRW, decode_pkg::OP_ADD_LITERAL_OP, decode_pkg::OP_ANDLW, decode_pkg::OP_IORLW,
      decode_pkg::OP_MOVLW, decode_pkg::OP_LITERAL_MINUS_ACC_OP, decode_pkg::OP_XORLW: next_acc_only = 1'b1;
      decode_pkg::OP_CALL, decode_pkg::OP_ACCCALL, decode_pkg::OP_IRET, decode_pkg::OP_RET: begin
        next_pc_change = 1'b1; // RL3
      end
      decode_pkg::OP_RETLIT: begin
        next_pc_change = 1'b1; // RL3
        next_acc_only  = 1'b1;
      end
      decode_pkg::OP_JUMP, decode_pkg::OP_RELBR, decode_pkg::OP_ACCBR: next_pc_change = 1'b1; // RL4
      decode_pkg::OP_ILOAD, decode_pkg::OP_ILOADK: begin
        next_ptr_op   = 1'b1;
        next_acc_only = 1'b1;
      end
      decode_pkg::OP_ISTORE, decode_pkg::OP_ISTOREK: next_ptr_op = 1'b1;
      default: next_file_op = 1'b0;
    endcase

    // Status flag update enables
    next_c  = 1'b0;
    next_dc = 1'b0;
    next_z  = 1'b0;
    case (next_op)
      decode_pkg::OP_ADDWF, decode_pkg::OP_ADD_WITH_CARRY_OP, decode_pkg::OP_SUBWF, decode_pkg::OP_SUBTRACT_WITH_BORROW_OP,
      decode_pkg::OP_ADD_LITERAL_OP, decode_pkg::OP_LITERAL_MINUS_ACC_OP: begin
        next_c  = 1'b1; // RL22
        next_dc = 1'b1;
        next_z  = 1'b1;
      end
      decode_pkg::OP_ASR, decode_pkg::OP_LSL, decode_pkg::OP_LSR: begin
        next_c = 1'b1;
        next_z = 1'b1;
      end
      decode_pkg::OP_RLF, decode_pkg::OP_RRF: next_c = 1'b1; // RL22
      decode_pkg::OP_ANDWF, decode_pkg::OP_IORWF, decode_pkg::OP_XORWF, decode_pkg::OP_COMF,
      decode_pkg::OP_DECF, decode_pkg::OP_INCF, decode_pkg::OP_MOVF, decode_pkg::OP_CLRF,
      decode_pkg::OP_CLRW, decode_pkg::OP_ANDLW, decode_pkg::OP_IORLW, decode_pkg::OP_XORLW,
      decode_pkg::OP_ILOAD, decode_pkg::OP_ILOADK: begin
        next_z = 1'b1; // RL22
      end
      default: next_z = 1'b0;
    endcase

    // Pointer select of an indirect port or pointer move
    case (next_op)
      decode_pkg::OP_ILOAD, decode_pkg::OP_ISTORE: next_ptr_sel = w[decode_pkg::PSEL_INC_BIT]; // RL15
      default:                                     next_ptr_sel = w[decode_pkg::PSEL_OFS_BIT]; // RL15
    endcase
    if (next_file_op) begin
      next_ptr_sel = w[0];
    end
    next_extra = ((next_file_op && w[decode_pkg::FILE_W-1:1] == decode_pkg::INDIRECT_FILE_PORT_UPPER) || next_ptr_op)
                 && (next_ptr_sel ? indirect_pointer1_msb : indirect_pointer0_msb); // RL6

    // Program counter targets
    case (next_op)
      decode_pkg::OP_RELBR: next_target = pc_plus1 + decode_pkg::PCW'($signed(w[decode_pkg::REL_W-1:0])); // RL24 RL14
      decode_pkg::OP_ACCBR: next_target = pc_plus1 + decode_pkg::PCW'(acc_value);
      decode_pkg::OP_ACCCALL: next_target = {program_page_latch, acc_value};
      default: next_target = {program_page_latch[decode_pkg::PAGE_W-1:decode_pkg::PAGE_JMP_LSB],
                              w[decode_pkg::TGT_W-1:0]}; // RL23 RL12
    endcase
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  decode_pkg::seq_state_t state;
  decode_pkg::seq_state_t next_state;
  logic                   pc_change;
  logic                   skip_op;
  logic                   extra_pending;
  logic                   two_cycle;

  assign two_cycle = pc_change || (skip_op && cond_true); // RL5

  always_comb begin
    case (state)
      decode_pkg::ST_EXEC: begin
        if (extra_pending) begin
          next_state = decode_pkg::ST_EXTRA; // RL6
        end else if (two_cycle) begin
          next_state = decode_pkg::ST_FLUSH; // RL5
        end else begin
          next_state = decode_pkg::ST_EXEC;
        end
      end
      decode_pkg::ST_EXTRA: next_state = two_cycle ? decode_pkg::ST_FLUSH : decode_pkg::ST_EXEC;
      decode_pkg::ST_FLUSH: next_state = decode_pkg::ST_EXEC;
      default:              next_state = decode_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= decode_pkg::ST_EXEC;
    end else if (ph.last) begin
      state <= next_state; // RL2
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cycle_start <= 1'b0;
      word_taken  <= 1'b0;
      extra_cycle <= 1'b0;
      nop_cycle   <= 1'b0;
    end else begin
      cycle_start <= ph.last;
      word_taken  <= ph.last && next_state == decode_pkg::ST_EXEC && instr_valid;
      if (ph.last) begin
        extra_cycle <= next_state == decode_pkg::ST_EXTRA; // RL6
        nop_cycle   <= next_state == decode_pkg::ST_FLUSH; // RL5
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoded fields, loaded when a new word is taken
  // ----------------------------------------------------------------
  logic take;
  logic bit_test;
  assign take     = ph.last && next_state == decode_pkg::ST_EXEC;
  assign bit_test = next_op inside {decode_pkg::OP_BTSC, decode_pkg::OP_BTSS};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      op                <= decode_pkg::OP_NOP;
      file_addr         <= '0;
      dest_to_file      <= 1'b0;
      bit_num           <= '0;
      literal8          <= '0;
      page_literal      <= '0;
      bank_literal      <= '0;
      ptr_sel           <= 1'b0;
      ptr_offset        <= '0;
      pointer_step_mode <= '0;
      jump_target       <= '0;
    end else if (take) begin
      op                <= next_op;
      file_addr         <= w[decode_pkg::FILE_W-1:0]; // RL9 RL10
      dest_to_file      <= w[decode_pkg::DEST_BIT]; // RL9
      bit_num           <= w[decode_pkg::BIT_LSB +: decode_pkg::BIT_W]; // RL10
      literal8          <= w[decode_pkg::LIT_W-1:0]; // RL11
      page_literal      <= w[decode_pkg::PAGE_W-1:0]; // RL13
      bank_literal      <= w[decode_pkg::BANK_W-1:0]; // RL13
      ptr_sel           <= next_ptr_sel;
      ptr_offset        <= w[decode_pkg::OFS_W-1:0]; // RL15
      pointer_step_mode <= w[decode_pkg::MODE_W-1:0]; // RL16
      jump_target       <= next_target;
    end
  end

  // Controls other than indirect_prog_access drop during a flushed cycle so the datapath sees a clean no-op
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pc_change            <= 1'b0;
      skip_op              <= 1'b0;
      extra_pending        <= 1'b0;
      file_read            <= 1'b0;
      file_write           <= 1'b0;
      acc_write            <= 1'b0;
      upd_c                <= 1'b0;
      upd_dc               <= 1'b0;
      upd_z                <= 1'b0;
      upd_to_pd            <= 1'b0;
      indirect_prog_access <= 1'b0;
    end else if (take) begin
      pc_change            <= next_pc_change;
      skip_op              <= next_skip_op;
      extra_pending        <= next_extra;
      file_read            <= next_file_op || next_ptr_op; // RL7
      file_write           <= next_always_wr || (next_file_op && w[decode_pkg::DEST_BIT] && !bit_test)
                              || next_op inside {decode_pkg::OP_ISTORE, decode_pkg::OP_ISTOREK}; // RL8
      acc_write            <= next_acc_only || (next_file_op && !next_always_wr && !w[decode_pkg::DEST_BIT]
                              && !bit_test); // RL8
      upd_c                <= next_c;
      upd_dc               <= next_dc;
      upd_z                <= next_z;
      upd_to_pd            <= next_op == decode_pkg::OP_WDTCLR || next_op == decode_pkg::OP_STANDBY; // RL21
      indirect_prog_access <= next_extra;
    end else if (ph.last) begin
      extra_pending <= 1'b0;
      if (next_state == decode_pkg::ST_FLUSH) begin
        pc_change     <= 1'b0;
        skip_op       <= 1'b0;
        file_read     <= 1'b0;
        file_write    <= 1'b0;
        acc_write     <= 1'b0;
        upd_c         <= 1'b0;
        upd_dc        <= 1'b0;
        upd_z         <= 1'b0;
        upd_to_pd     <= 1'b0;
      end
    end
  end

endmodule

// [pkg/decode_pkg.sv]
// Constants, field layouts, operation codes and sequencer states for the instruction decoder.
// Assumes a single core clock; every instruction word arrives whole from the fetch unit.
//
// Notes on behaviour
// RL1 - Each instruction is one 14-bit word holding opcode and all operands.
// RL2 - One instruction cycle is four core clocks, paced by a divide-by-four.
// RL3 - Calls, accumulator calls and every return take two instruction cycles.
// RL4 - Jumps and both branch kinds take two cycles; skips too when taken.
// RL5 - A changed PC or a true test adds a second cycle run as a no-op.
// RL6 - Indirect file access adds a cycle when the pointer's top bit is set.
// RL7 - Every file instruction reads its register first, even when it only writes.
// RL8 - Destination bit 0 sends the result to the accumulator, 1 to the file.
// RL9 - Byte ops: file address bits 6:0, destination bit 7, opcode above.
// RL10 - Bit ops: opcode 13:10, bit number 9:7, file address 6:0.
// RL11 - General literal ops: 8-bit literal in 7:0, opcode in 13:8.
// RL12 - Call and jump: 11-bit target in 10:0, opcode in 13:11.
// RL13 - Page latch load takes 7 bits from 6:0; bank load 5 bits from 4:0.
// RL14 - Relative branch: signed 9-bit offset in 8:0, opcode in 13:9.
// RL15 - Pointer offset: select bit 6, 6-bit literal 5:0; step form select plus mode.
// RL16 - Indirect moves support pre/post increment/decrement via a two-bit mode.
// RL17 - Decode add-with-carry, subtract-with-borrow and the three shift opcodes.
// RL18 - Decode decrement/increment skip-if-zero and both bit-test skips.
// RL19 - Decode literal add, subtract, AND, OR, XOR and move opcodes.
// RL20 - Fixed words by low nibble: return, interrupt return, accumulator call, branch.
// RL21 - No-op, software reset, standby and watchdog clear; last two touch time-out/power-down.
// RL22 - Flag update enables per class: arithmetic C/DC/Z, logic and moves Z, rotates C.
// RL23 - Literal call and jump fill the upper PC bits from the page latch.
// RL24 - Relative branch target is instruction address plus one plus offset.
// RL25 - Undefined opcode patterns execute as a no-operation.

package decode_pkg;

  localparam int IW           = 14;
  localparam int PCW          = 15;
  localparam int FILE_W       = 7;
  localparam int DEST_BIT     = 7;
  localparam int BIT_LSB      = 7;
  localparam int BIT_W        = 3;
  localparam int LIT_W        = 8;
  localparam int TGT_W        = 11;
  localparam int PAGE_W       = 7;
  localparam int PAGE_JMP_LSB = 3;
  localparam int BANK_W       = 5;
  localparam int REL_W        = 9;
  localparam int PSEL_OFS_BIT = 6;
  localparam int PSEL_INC_BIT = 2;
  localparam int OFS_W        = 6;
  localparam int MODE_W       = 2;
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [IW-1:0]     NOP_WORD   = 14'h0000;
  localparam logic [FILE_W-2:0] INDIRECT_FILE_PORT_UPPER = 6'h00;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADDWF, OP_ADD_WITH_CARRY_OP, OP_ANDWF, OP_ASR, OP_LSL, OP_LSR, OP_CLRF, OP_CLRW,
    OP_COMF, OP_DECF, OP_INCF, OP_IORWF, OP_MOVF, OP_MOVWF, OP_RLF, OP_RRF, OP_SUBWF,
    OP_SUBTRACT_WITH_BORROW_OP, OP_SWAPF, OP_XORWF, OP_DECSZ, OP_INCSZ, OP_BCF, OP_BSF, OP_BTSC, OP_BTSS,
    OP_ADD_LITERAL_OP, OP_ANDLW, OP_IORLW, OP_BANKLD, OP_PAGELD, OP_MOVLW, OP_LITERAL_MINUS_ACC_OP, OP_XORLW,
    OP_RELBR, OP_ACCBR, OP_CALL, OP_ACCCALL, OP_JUMP, OP_IRET, OP_RETLIT, OP_RET,
    OP_WDTCLR, OP_OPTLD, OP_SWRESET, OP_STANDBY, OP_TRISLD, OP_PTRADD, OP_ILOAD,
    OP_ILOADK, OP_ISTORE, OP_ISTOREK
  } op_t;

  typedef enum logic [2:0] {
    ST_EXEC  = 3'b001,
    ST_EXTRA = 3'b010,
    ST_FLUSH = 3'b100
  } seq_state_t;

endpackage

// [pkg/phase_if.sv]
// Carries the instruction-cycle phase from the divider to the decoder.
// Both ends sit on core_clk.

`timescale 1ns/100ps

interface phase_if;
  logic [1:0] count;
  logic       last;

  modport src (output count, output last);
  modport dst (input  count, input  last);
endinterface

// [verilog/cycle_phase_div.sv]
// Divide-by-four phase counter that paces instruction cycles.
// Runs freely from reset on core_clk; last marks the final clock of a cycle.

`timescale 1ns/100ps

module cycle_phase_div (
  input  wire logic core_clk,
  input  wire logic nrst,
  phase_if.src      ph
);

  logic [1:0] count;

  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 2'h0;
    end else begin
      count <= count + 2'h1; // RL2
    end
  end

  assign ph.count = count;
  assign ph.last  = (count == 2'(decode_pkg::OSC_PER_CYCLE - 1)); // RL2

endmodule

// [testbench/decode_sva.sv]
// Checker on decoder ports: pacing, flush and extra cycles, routing.
// Single core_clk domain; bound to every decoder instance.
`timescale 1ns/100ps
module decode_sva (
  input wire logic            core_clk,
  input wire logic            nrst,
  input wire logic [1:0]      phase,
  input wire logic            cycle_start,
  input wire logic            word_taken,
  input wire decode_pkg::op_t op,
  input wire logic            nop_cycle,
  input wire logic            extra_cycle,
  input wire logic            file_read,
  input wire logic            file_write,
  input wire logic            acc_write,
  input wire logic            dest_to_file,
  input wire logic            cond_true,
  input wire logic            indirect_prog_access
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  a_phase_steps: assert property (phase != 2'h3 |=> phase == $past(phase) + 2'h1)
    else $error("phase did not advance");
  a_start_period: assert property (cycle_start |-> phase == 2'h0 ##1 !cycle_start [*3] ##1 cycle_start)
    else $error("cycle start off its four clock pace");
  a_taken_start: assert property (word_taken |-> cycle_start && !nop_cycle && !extra_cycle)
    else $error("word taken outside a fresh cycle");
  a_branch_flush: assert property (word_taken && op inside {decode_pkg::OP_CALL, decode_pkg::OP_JUMP,
    decode_pkg::OP_RELBR, decode_pkg::OP_ACCBR, decode_pkg::OP_ACCCALL, decode_pkg::OP_RET, decode_pkg::OP_IRET}
    |-> ##4 nop_cycle) else $error("branch without flush cycle");
  a_skip_flush: assert property (word_taken && !indirect_prog_access && op inside {decode_pkg::OP_DECSZ,
    decode_pkg::OP_INCSZ, decode_pkg::OP_BTSC, decode_pkg::OP_BTSS} |-> ##4 nop_cycle == $past(cond_true))
    else $error("skip flush does not follow the test");
  a_flush_quiet: assert property (nop_cycle |-> !file_write && !acc_write && !word_taken)
    else $error("flush cycle not idle");
  a_flush_len: assert property ($rose(nop_cycle) |-> nop_cycle [*4] ##1 !nop_cycle)
    else $error("flush cycle length wrong");
  a_extra_ptr: assert property (word_taken && indirect_prog_access |-> ##4 extra_cycle)
    else $error("no extra cycle for program memory pointer");
  a_write_reads: assert property (word_taken && file_write |-> file_read)
    else $error("file write without read");
  a_dest_route: assert property (word_taken && op == decode_pkg::OP_ADDWF |->
    file_write == dest_to_file && acc_write != dest_to_file) else $error("result routed wrongly");
  c_flush: cover property (nop_cycle && cycle_start);
  c_extra: cover property (extra_cycle && cycle_start);
  c_jump: cover property (word_taken && op == decode_pkg::OP_JUMP);
endmodule
bind cpu_instruction_decode decode_sva chk (.*);

// [testbench/fetch_model.sv]
// Fetch-side model: offers program words in order, steps only when one is taken.
// The bench loads the whole image at time zero.
`timescale 1ns/100ps
module fetch_model (
  input  wire logic   core_clk,
  input  wire logic   nrst,
  input  wire logic   word_taken,
  output logic [13:0] instr_word,
  output logic [14:0] instr_addr
);
  logic [13:0] mem [64];
  // A refused word stays on offer until taken
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst) instr_addr <= 15'h0000;
    else if (word_taken) instr_addr <= instr_addr + 15'h0001;
  assign instr_word = mem[instr_addr[5:0]];
endmodule

// [testbench/tb_cpu_instruction_decode.sv]
// Bench: runs a program through the decoder, checks decode, fields and cycle count per word.
// Pointer 1 addresses program memory throughout; pointer 0 does not.
`timescale 1ns/100ps
module tb_cpu_instruction_decode;
  typedef struct {logic [13:0] w; decode_pkg::op_t op; int c;} row_t;
  localparam int N = 30;
  row_t rows [N] = '{'{14'h0785, decode_pkg::OP_ADDWF, 1}, '{14'h0705, decode_pkg::OP_ADDWF, 1},
    '{14'h3D2A, decode_pkg::OP_ADD_WITH_CARRY_OP, 1}, '{14'h3BAA, decode_pkg::OP_SUBTRACT_WITH_BORROW_OP, 1}, '{14'h3702, decode_pkg::OP_ASR, 1},
    '{14'h3502, decode_pkg::OP_LSL, 1}, '{14'h3602, decode_pkg::OP_LSR, 1}, '{14'h0B10, decode_pkg::OP_DECSZ, 1},
    '{14'h0F10, decode_pkg::OP_INCSZ, 2}, '{14'h1800, decode_pkg::OP_BTSC, 1}, '{14'h1F85, decode_pkg::OP_BTSS, 2},
    '{14'h3E55, decode_pkg::OP_ADD_LITERAL_OP, 1}, '{14'h3C55, decode_pkg::OP_LITERAL_MINUS_ACC_OP, 1}, '{14'h3955, decode_pkg::OP_ANDLW, 1},
    '{14'h3855, decode_pkg::OP_IORLW, 1}, '{14'h3A55, decode_pkg::OP_XORLW, 1}, '{14'h3055, decode_pkg::OP_MOVLW, 1},
    '{14'h0008, decode_pkg::OP_RET, 2}, '{14'h0009, decode_pkg::OP_IRET, 2}, '{14'h000A, decode_pkg::OP_ACCCALL, 2},
    '{14'h000B, decode_pkg::OP_ACCBR, 2}, '{14'h0000, decode_pkg::OP_NOP, 1}, '{14'h0001, decode_pkg::OP_SWRESET, 1},
    '{14'h0063, decode_pkg::OP_STANDBY, 1}, '{14'h0064, decode_pkg::OP_WDTCLR, 1}, '{14'h2123, decode_pkg::OP_CALL, 2},
    '{14'h2923, decode_pkg::OP_JUMP, 2}, '{14'h3301, decode_pkg::OP_RELBR, 2}, '{14'h0801, decode_pkg::OP_MOVF, 2},
    '{14'h0002, decode_pkg::OP_NOP, 1}};
  logic            core_clk = 1'b0, nrst = 1'b0, cond_true = 1'b0, instr_valid = 1'b1;
  logic [13:0]     instr_word;
  logic [14:0]     instr_addr, jump_target;
  logic [1:0]      phase;
  logic            word_taken;
  decode_pkg::op_t op;
  logic [6:0]      file_addr;
  logic [2:0]      bit_num;
  logic [7:0]      literal8;
  int              bad_count = 0, num_checks = 0, k = 0, gap = 0;
  always #10 core_clk = ~core_clk;
  fetch_model fm (.core_clk(core_clk), .nrst(nrst), .word_taken(word_taken), .instr_word(instr_word),
    .instr_addr(instr_addr));
  cpu_instruction_decode dut (.core_clk(core_clk), .nrst(nrst), .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_addr(instr_addr), .acc_value(8'h3C), .program_page_latch(7'h55), .indirect_pointer0_msb(1'b0),
    .indirect_pointer1_msb(1'b1), .cond_true(cond_true), .phase(phase), .cycle_start(), .word_taken(word_taken),
    .op(op), .nop_cycle(), .extra_cycle(), .file_addr(file_addr), .dest_to_file(), .bit_num(bit_num),
    .literal8(literal8), .page_literal(), .bank_literal(), .ptr_sel(), .ptr_offset(), .pointer_step_mode(),
    .jump_target(jump_target), .file_read(), .file_write(), .acc_write(), .upd_c(), .upd_dc(), .upd_z(),
    .upd_to_pd(), .indirect_prog_access());
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Monitor: each taken word against its row
  // --------------------------------------------------------------
  always @(negedge core_clk) begin
    gap++;
    if (word_taken === 1'b1 && k < N) begin
      if (k > 0) chk(gap, 4 * rows[k-1].c);
      chk(op, rows[k].op);
      chk({file_addr, bit_num, literal8}, {rows[k].w[6:0], rows[k].w[9:7], rows[k].w[7:0]});
      if (rows[k].w[13:12] == 2'h2) chk(jump_target, {4'hA, rows[k].w[10:0]});
      if (op === decode_pkg::OP_RELBR) chk(jump_target, 15'(k + 1) + {{6{rows[k].w[8]}}, rows[k].w[8:0]});
      gap = 0;
      k++;
    end
  end
  // Skip rows with two cycles get a true test
  always @(posedge core_clk) if (word_taken === 1'b1) cond_true <= (rows[k-1].c == 2);
  initial begin
    for (int i = 0; i < 64; i++) fm.mem[i] = (i < N) ? rows[i].w : 14'h0000;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    for (int t = 0; t < 1000 && k < N; t++) @(posedge core_clk);
    chk(k, N);
    @(posedge core_clk);
    nrst <= 1'b0;
    @(negedge core_clk);
    chk({op, phase, word_taken}, {decode_pkg::OP_NOP, 2'h0, 1'b0});
    @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk({word_taken, phase}, {1'b1, 2'h0});
    wrap_up();
  end
  initial begin
    #40000;
    bad_count++;
    wrap_up();
  end
endmodule
